// File: aic_pkg.sv
// Package: constants and types for the analog input conditioning block
`default_nettype none
package aic_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 16;
  localparam int CHW = 4;
  localparam int DW = 16;
  localparam int HDEPTH = 128;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_FLAG = 8'h08;
  localparam logic [7:0] REG_UNCAL = 8'h0C;
  localparam logic [7:0] REG_CHG = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_PSEL = 8'h18;
  localparam logic [7:0] REG_SCALE = 8'h1C;
  localparam logic [7:0] REG_THR = 8'h40;
  localparam logic [7:0] REG_PRE = 8'h80;
  localparam logic [7:0] REG_VAL = 8'hC0;
  // ----------------------------------------
  // Control and status fields
  // ----------------------------------------
  localparam int CTL_F60 = 0;
  localparam int CTL_DEP = 1;
  localparam int CTL_RNG = 4;
  localparam int CTL_EGU = 6;
  localparam int CTL_LEG = 7;
  localparam int CTL_SLP = 8;
  localparam int CTL_FRZ = 9;
  localparam int CTL_TST = 10;
  localparam int CTL_TF60 = 11;
  localparam int CTL_TDEP = 12;
  localparam int ST_FLT = 0;
  localparam int ST_FLTS = 1;
  localparam int ST_SLP = 2;
  // ----------------------------------------
  // Reset values and scaling
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_000A;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_7FFF;
  localparam logic [31:0] SCALE_RST = 32'h0000_1000;
  localparam logic [2:0] DEP_RST = 3'h5;
  localparam int SCL_SHIFT = 12;
  localparam int LEG_SHIFT = 4;
  // ----------------------------------------
  // Range limits (-32256, 32256, 6144, -256)
  // ----------------------------------------
  localparam logic signed [15:0] LIM_HI = 16'sh7E00;
  localparam logic signed [15:0] LIM_LO_BIP = 16'sh8200;
  localparam logic signed [15:0] LIM_LO_OFS = 16'sh1800;
  localparam logic signed [15:0] LIM_LO_UNI = 16'shFF00;
  localparam logic [15:0] UNCAL_CODE = 16'h8000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RNG_BIP = 2'h0,
    RNG_OFS = 2'h1,
    RNG_UNI = 2'h2
  } aic_rng_type;
  typedef enum logic [3:0] {
    MD_RUN = 4'b0001,
    MD_FRZ = 4'b0010,
    MD_FLT = 4'b0100,
    MD_SLP = 4'b1000
  } aic_mode_type;
endpackage
`default_nettype wire

// File: aic_smp_if.sv
// Interface: one channel sample with its channel number
`default_nettype none
interface aic_smp_if;
  import aic_pkg::*;
  logic valid;
  logic [CHW-1:0] ch;
  logic signed [DW-1:0] data;
  modport src (output valid, output ch, output data);
  modport snk (input valid, input ch, input data);
endinterface
`default_nettype wire

// File: aic_avg.sv
// Running-average smoothing over the last 2**depth samples per channel
`default_nettype none
module aic_avg (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] depth_i,
  // Sample streams
  aic_smp_if.snk raw,
  aic_smp_if.src avg
);
  import aic_pkg::*;

  logic signed [15:0] hist [0:NCH*HDEPTH-1];
  logic [6:0] ptr [0:NCH-1];
  logic [7:0] fill [0:NCH-1];
  logic signed [22:0] sum [0:NCH-1];
  logic [2:0] depth_q;
  logic [7:0] span;
  logic [6:0] old_idx;
  logic signed [15:0] oldest;
  logic signed [22:0] next_sum;
  logic take;

  always_comb begin
    span = 8'(8'h01 << depth_i);
    old_idx = 7'({1'b0, ptr[raw.ch]} - span);
    oldest = (fill[raw.ch] >= span) ? hist[{raw.ch, old_idx}] : 16'sh0000;
    next_sum = sum[raw.ch] + 23'(raw.data) - 23'(oldest);
    take = raw.valid && (depth_i == depth_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_q <= DEP_RST;
      for (int i = 0; i < NCH; i++) begin
        sum[i] <= 23'sh000000;
        fill[i] <= 8'h00;
        ptr[i] <= 7'h00;
      end
    end else if (ce_i) begin
      depth_q <= depth_i;
      if (depth_i != depth_q) begin
        for (int i = 0; i < NCH; i++) begin
          sum[i] <= 23'sh000000;
          fill[i] <= 8'h00;
        end
      end else if (raw.valid) begin
        sum[raw.ch] <= next_sum;
        ptr[raw.ch] <= ptr[raw.ch] + 7'h01;
        if (fill[raw.ch] != 8'h80) begin
          fill[raw.ch] <= fill[raw.ch] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && take) begin
      hist[{raw.ch, ptr[raw.ch]}] <= raw.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg.valid <= 1'b0;
      avg.ch <= 4'h0;
      avg.data <= 16'sh0000;
    end else if (ce_i) begin
      avg.valid <= take;
      avg.ch <= raw.ch;
      avg.data <= 16'(next_sum >>> depth_i);
    end
  end

  property p_depth1;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && take && depth_i == 3'h0 |=> avg.valid && avg.data == $past(raw.data);
  endproperty
  a_depth1: assert property (p_depth1) else $error("depth 1 average differs from input");
endmodule
`default_nettype wire

// File: aic_rng.sv
// Range check of one averaged sample against the selected input range
`default_nettype none
module aic_rng (
  // Range and sample
  input wire aic_pkg::aic_rng_type range_i,
  aic_smp_if.snk smp,
  // Flags
  output logic under_o,
  output logic over_o
);
  import aic_pkg::*;

  logic signed [15:0] lo;
  logic uncal;

  always_comb begin
    case (range_i)
      RNG_OFS: lo = LIM_LO_OFS;
      RNG_UNI: lo = LIM_LO_UNI;
      default: lo = LIM_LO_BIP;
    endcase
    // Converter reports an uncalibrated channel with its lowest code
    uncal = (smp.data == UNCAL_CODE);
    under_o = uncal || (smp.data < lo);
    over_o = uncal || (smp.data > LIM_HI);
  end
endmodule
`default_nettype wire

// File: aic_top.sv
// Top: analog input conditioning with Wishbone register access
// Summary of operation
// - Channel values are signed 16-bit two's complement, sign included.
// - One 50/60 Hz filter select for the whole module, 50 Hz default.
// - Each channel smoothed as running average of recent samples.
// - Per-input threshold; moves beyond it flag a change; zero disables.
// - Current modules: bipolar 20 mA default, or 4-20 mA, per module.
// - Voltage modules: bipolar 5 V default, 0-5 V or 1-5 V, per module.
// - Bipolar: full scale is +-32000; below -32256 sets under-range.
// - Every range: top is 32000; above 32256 sets over-range.
// - Offset ranges: bottom is 6400; below 6144 sets under-range.
// - Range selects limits; 0-5 V: below -256 sets under-range.
// - Under and over flags together mean the channel is uncalibrated.
// - Per input: hold last value or preset, reported on module failure.
// - Masked input reports its preset in normal operation; off by default.
// - Sleep stops measuring and reports every preset value.
// - Freeze reports held or preset values instead of live data.
// - Failure lights fault output and is readable in status.
// - Values reported as raw counts or scaled engineering units.
// - Values reported at native or reduced legacy resolution.
// - Test session may override filter setup; setup restored afterwards.
`default_nettype none
module aic_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Converter side
  input wire logic smp_valid_i,
  input wire logic [aic_pkg::CHW-1:0] smp_chan_i,
  input wire logic [aic_pkg::DW-1:0] smp_data_i,
  output logic filt60_o,
  output logic sleep_o,
  // Failure pin and indicators
  input wire logic fault_i,
  output logic err_led_o,
  output logic [aic_pkg::NCH-1:0] under_range_led_o,
  output logic [aic_pkg::NCH-1:0] over_range_led_o
);
  import aic_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] scale;
  logic [15:0] mask;
  logic [15:0] hold_last_value;
  logic [15:0] change_detect;
  logic [15:0] thr [0:NCH-1];
  logic [15:0] preset_value [0:NCH-1];
  logic [15:0] live [0:NCH-1];
  logic signed [15:0] ref_v [0:NCH-1];
  logic fault_m;
  logic fault_s;
  logic fault_stk;
  aic_mode_type mode;
  aic_mode_type next_mode;
  logic acc;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rd_data;
  logic [3:0] idx;
  logic [2:0] eff_dep;
  aic_rng_type rng;
  logic chk_under;
  logic chk_over;
  logic upd;
  logic signed [31:0] prod;
  logic signed [15:0] egu_v;
  logic signed [15:0] base_v;
  logic signed [15:0] fmt_v;
  logic signed [16:0] diff;
  logic [16:0] mag;
  logic moved;

  aic_smp_if raw_if ();
  aic_smp_if avg_if ();

  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  // no measuring while asleep
  assign raw_if.valid = smp_valid_i && (mode != MD_SLP);
  assign raw_if.ch = smp_chan_i;
  assign raw_if.data = $signed(smp_data_i);

  assign eff_dep = ctrl[CTL_TST] ? ctrl[CTL_TDEP +: 3] : ctrl[CTL_DEP +: 3];
  assign rng = aic_rng_type'(ctrl[CTL_RNG +: 2]);
  assign upd = avg_if.valid && (mode != MD_SLP);

  aic_avg u_avg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .depth_i(eff_dep),
    .raw(raw_if),
    .avg(avg_if)
  );

  aic_rng u_rng (
    .range_i(rng),
    .smp(avg_if),
    .under_o(chk_under),
    .over_o(chk_over)
  );

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  always_comb begin
    if (ctrl[CTL_SLP]) begin
      next_mode = MD_SLP;
    end else if (fault_s) begin
      next_mode = MD_FLT;
    end else if (ctrl[CTL_FRZ]) begin
      next_mode = MD_FRZ;
    end else begin
      next_mode = MD_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MD_RUN;
    end else if (ce_i) begin
      mode <= next_mode;
    end
  end

  // Fault pin comes from outside, so it is synchronised first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_m <= 1'b0;
      fault_s <= 1'b0;
      err_led_o <= 1'b0;
    end else if (ce_i) begin
      fault_m <= fault_i;
      fault_s <= fault_m;
      err_led_o <= fault_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt60_o <= 1'b0;
      sleep_o <= 1'b0;
    end else if (ce_i) begin
      filt60_o <= ctrl[CTL_TST] ? ctrl[CTL_TF60] : ctrl[CTL_F60];
      sleep_o <= ctrl[CTL_SLP];
    end
  end

  // ----------------------------------------
  // Value formatting
  // ----------------------------------------
  always_comb begin
    prod = avg_if.data * $signed(scale[15:0]);
    egu_v = 16'(prod >>> SCL_SHIFT) + $signed(scale[31:16]);
    base_v = ctrl[CTL_EGU] ? egu_v : avg_if.data;
    fmt_v = ctrl[CTL_LEG] ? (base_v >>> LEG_SHIFT) : base_v;
    diff = 17'(avg_if.data) - 17'(ref_v[avg_if.ch]);
    mag = diff[16] ? 17'(-diff) : 17'(diff);
    moved = (thr[avg_if.ch] != 16'h0000) && (mag > {1'b0, thr[avg_if.ch]});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        live[i] <= 16'h0000;
      end
    end else if (ce_i && avg_if.valid && mode == MD_RUN) begin
      if (!(chk_under && chk_over)) begin
        live[avg_if.ch] <= fmt_v;
      end
    end
  end

  // Range flags drive the indicators directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      under_range_led_o <= 16'h0000;
      over_range_led_o <= 16'h0000;
    end else if (ce_i && upd) begin
      under_range_led_o[avg_if.ch] <= chk_under;
      over_range_led_o[avg_if.ch] <= chk_over;
    end
  end

  // Presented value by mode, mask and hold choice
  function automatic logic [15:0] present(input logic [3:0] c);
    case (mode)
      MD_SLP: present = preset_value[c];
      MD_FLT, MD_FRZ: present = hold_last_value[c] ? live[c] : preset_value[c];
      default: present = mask[c] ? preset_value[c] : live[c];
    endcase
  endfunction

  // ----------------------------------------
  // Wishbone access
  // ----------------------------------------
  assign acc = cyc_i && stb_i;
  // Writes land on the edge where the master sees ack
  assign wr = acc && we_i && ack_o;
  assign idx = adr_i[5:2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  always_comb begin
    rd_data = 32'h0000_0000;
    if (adr_i[7:6] == REG_THR[7:6]) begin
      rd_data = {16'h0000, thr[idx]};
    end else if (adr_i[7:6] == REG_PRE[7:6]) begin
      rd_data = {16'h0000, preset_value[idx]};
    end else if (adr_i[7:6] == REG_VAL[7:6]) begin
      rd_data = {16'h0000, present(idx)};
    end else begin
      case (adr_i[5:2])
        REG_CTRL[5:2]: rd_data = ctrl;
        REG_STAT[5:2]: rd_data = {29'h0, mode == MD_SLP, fault_stk, fault_s};
        REG_FLAG[5:2]: rd_data = {over_range_led_o, under_range_led_o};
        REG_UNCAL[5:2]: rd_data = {16'h0000, over_range_led_o & under_range_led_o};
        REG_CHG[5:2]: rd_data = {16'h0000, change_detect};
        REG_MASK[5:2]: rd_data = {16'h0000, mask};
        REG_PSEL[5:2]: rd_data = {16'h0000, ~hold_last_value};
        REG_SCALE[5:2]: rd_data = scale;
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= acc && !ack_o;
      if (acc && !ack_o) begin
        dat_o <= rd_data;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      scale <= SCALE_RST;
      mask <= 16'h0000;
      hold_last_value <= 16'hFFFF;
    end else if (ce_i && wr && adr_i[7:6] == 2'h0) begin
      case (adr_i[5:2])
        REG_CTRL[5:2]: ctrl <= ((ctrl & ~wmask) | (dat_i & wmask)) & CTRL_WMASK;
        REG_SCALE[5:2]: scale <= (scale & ~wmask) | (dat_i & wmask);
        REG_MASK[5:2]: mask <= (mask & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        REG_PSEL[5:2]: hold_last_value <= ~((~hold_last_value & ~wmask[15:0]) |
                                            (dat_i[15:0] & wmask[15:0]));
        default: ctrl <= ctrl;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        thr[i] <= 16'h0000;
        preset_value[i] <= 16'h0000;
      end
    end else if (ce_i && wr) begin
      if (adr_i[7:6] == REG_THR[7:6]) begin
        thr[idx] <= (thr[idx] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
      end else if (adr_i[7:6] == REG_PRE[7:6]) begin
        preset_value[idx] <= (preset_value[idx] & ~wmask[15:0]) |
                             (dat_i[15:0] & wmask[15:0]);
      end
    end
  end

  // ----------------------------------------
  // Sticky events
  // ----------------------------------------
  // change detection, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_detect <= 16'h0000;
      for (int i = 0; i < NCH; i++) begin
        ref_v[i] <= 16'sh0000;
      end
    end else if (ce_i) begin
      for (int i = 0; i < NCH; i++) begin
        if (upd && moved && avg_if.ch == 4'(i)) begin
          change_detect[i] <= 1'b1;
          ref_v[i] <= avg_if.data;
        end else if (wr && adr_i == REG_CHG && wmask[i] && dat_i[i]) begin
          change_detect[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_stk <= 1'b0;
    end else if (ce_i) begin
      if (fault_s) begin
        fault_stk <= 1'b1;
      end else if (wr && adr_i == REG_STAT && sel_i[0] && dat_i[ST_FLTS]) begin
        fault_stk <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_over;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && upd && avg_if.data > LIM_HI |=> over_range_led_o[$past(avg_if.ch)];
  endproperty
  a_over: assert property (p_over) else $error("over-range flag not set");

  property p_under_bip;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && upd && rng == RNG_BIP && avg_if.data < LIM_LO_BIP
    |=> under_range_led_o[$past(avg_if.ch)];
  endproperty
  a_under_bip: assert property (p_under_bip) else $error("bipolar under flag missing");

  property p_under_ofs;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && upd && rng == RNG_OFS && avg_if.data >= LIM_LO_OFS
    |=> !under_range_led_o[$past(avg_if.ch)];
  endproperty
  a_under_ofs: assert property (p_under_ofs) else $error("offset range under set");

  property p_under_uni;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && upd && rng == RNG_UNI && avg_if.data < LIM_LO_UNI
    |=> under_range_led_o[$past(avg_if.ch)];
  endproperty
  a_under_uni: assert property (p_under_uni) else $error("0-5 V under flag missing");

  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MD_SLP && !wr |=> $stable(under_range_led_o) && $stable(change_detect);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state moved while asleep");

  property p_fault;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    fault_i [*3] |-> ##1 err_led_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault indicator late");

  property p_thr0;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && avg_if.valid && thr[avg_if.ch] == 16'h0000 && !change_detect[avg_if.ch]
    |=> !change_detect[$past(avg_if.ch)];
  endproperty
  a_thr0: assert property (p_thr0) else $error("change flagged with zero threshold");

  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && mode != MD_RUN |=> live[$past(avg_if.ch)] == $past(live[avg_if.ch]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("live value moved outside run");
endmodule
`default_nettype wire

// File: aic_adc_model.sv
// Converter model: feeds one signed sample per request on the sample bus, and none while sleep_i is high
`default_nettype none
module aic_adc_model (
  // Clock and sleep request
  input wire logic clk_i,
  input wire logic sleep_i,
  // Sample bus
  output logic smp_valid_o,
  output logic [aic_pkg::CHW-1:0] smp_chan_o,
  output logic [aic_pkg::DW-1:0] smp_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import aic_pkg::*;
  initial begin
    smp_valid_o = 1'b0;
    smp_chan_o = 4'h0;
    smp_data_o = 16'h0000;
  end
  task automatic send(input logic [CHW-1:0] ch, input logic [DW-1:0] d);
    @(posedge clk_i);
    if (sleep_i !== 1'b1) begin
      smp_valid_o <= 1'b1;
      smp_chan_o <= ch;
      smp_data_o <= d;
      @(posedge clk_i);
      // Idle bus shows inverted data so a stale sample is never mistaken for valid
      smp_valid_o <= 1'b0;
      smp_chan_o <= ~ch;
      smp_data_o <= ~d;
    end
  endtask
endmodule
`default_nettype wire

// File: tb_aic_top.sv
// Testbench: register-level checks of the analog input conditioning block
`default_nettype none
module tb_aic_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aic_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, fault_i, ack_o, filt60_o, sleep_o, err_led_o;
  logic ce, s_valid;
  logic [7:0] adr;
  logic [3:0] sel, s_ch;
  logic [31:0] dat, dat_o, q;
  logic [15:0] s_data;
  logic [15:0] under_range_led_o, over_range_led_o;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] sv [10] = '{16'h81FF, 16'h8200, 16'h7E00, 16'h7E01, 16'h17FF,
    16'h1800, 16'h7E01, 16'hFEFF, 16'hFF00, 16'h7E00};
  logic [1:0] rg [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  logic [1:0] ef [10] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
  aic_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .smp_valid_i(s_valid), .smp_chan_i(s_ch), .smp_data_i(s_data),
    .filt60_o(filt60_o), .sleep_o(sleep_o), .fault_i(fault_i), .err_led_o(err_led_o),
    .under_range_led_o(under_range_led_o), .over_range_led_o(over_range_led_o));
  aic_adc_model adc (.clk_i(clk_i), .sleep_i(sleep_o), .smp_valid_o(s_valid),
    .smp_chan_o(s_ch), .smp_data_o(s_data));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 32'h0, 32'h1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(nm, r, e);
  endtask
  task automatic rv(input logic [3:0] ch, input logic [15:0] e);
    logic [31:0] r;
    wb(1'b0, REG_VAL + {2'h0, ch, 2'h0}, 32'h0, r);
    chk("value", {16'h0, r[15:0]}, {16'h0, e});
  endtask
  task automatic smp(input logic [3:0] ch, input logic [15:0] d);
    adc.send(ch, d);
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    {cyc, stb, we, fault_i, adr, sel, dat} = '0;
    ce = 1'b1;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", REG_CTRL, CTRL_RST);
    rd("stat", REG_STAT, 32'h0);
    rd("scale", REG_SCALE, SCALE_RST);
    rd("mask", REG_MASK, 32'h0);
    rd("psel", REG_PSEL, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    chk("filt60", {31'h0, filt60_o}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(REG_CTRL, {26'h0, rg[i], 4'h0});
      smp(4'(i), sv[i]);
      wb(1'b0, REG_FLAG, 32'h0, q);
      chk("under", {31'h0, q[i]}, {31'h0, ef[i][0]});
      chk("over", {31'h0, q[i+16]}, {31'h0, ef[i][1]});
      chk("leds", {30'h0, over_range_led_o[i], under_range_led_o[i]}, {30'h0, ef[i]});
      rv(4'(i), sv[i]);
    end
    smp(4'hA, 16'h8000);
    rd("uncal", REG_UNCAL, 32'h0000_0400);
    wr(REG_CTRL, 32'h0000_0002);
    smp(4'hB, 16'h0064);
    rv(4'hB, 16'h0032);
    smp(4'hB, 16'h012C);
    rv(4'hB, 16'h00C8);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_THR + 8'h30, 32'h0000_000A);
    smp(4'hC, 16'h0005);
    rd("change", REG_CHG, 32'h0);
    smp(4'hC, 16'h0014);
    smp(4'hD, 16'h03E8);
    rd("change", REG_CHG, 32'h0000_1000);
    wr(REG_CHG, 32'h0000_1000);
    rd("change", REG_CHG, 32'h0);
    wr(REG_SCALE, 32'h0005_2000);
    wr(REG_CTRL, 32'h0000_0040);
    smp(4'hC, 16'h0014);
    rv(4'hC, 16'h002D);
    wr(REG_CTRL, 32'h0000_0080);
    smp(4'h3, 16'h7E01);
    rv(4'h3, 16'h07E0);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_PRE, 32'h0000_1234);
    wr(REG_MASK, 32'h0000_0001);
    rv(4'h0, 16'h1234);
    rv(4'h1, 16'h8200);
    wr(REG_MASK, 32'h0);
    wr(REG_PSEL, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0200);
    smp(4'h1, 16'h0100);
    rv(4'h1, 16'h8200);
    rv(4'h0, 16'h1234);
    wr(REG_CTRL, 32'h0);
    fault_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("err_led", {31'h0, err_led_o}, 32'h1);
    rd("stat", REG_STAT, 32'h0000_0003);
    rv(4'h0, 16'h1234);
    fault_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd("stat", REG_STAT, 32'h0000_0002);
    wr(REG_STAT, 32'h0000_0002);
    rd("stat", REG_STAT, 32'h0);
    wr(REG_PRE + 8'h14, 32'h0000_0777);
    wr(REG_CTRL, 32'h0000_0100);
    rd("stat", REG_STAT, 32'h0000_0004);
    chk("sleep", {31'h0, sleep_o}, 32'h1);
    smp(4'h5, 16'h0010);
    rv(4'h5, 16'h0777);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("filt60", {31'h0, filt60_o}, 32'h1);
    wr(REG_CTRL, 32'h0000_1C00);
    repeat (2) @(posedge clk_i);
    chk("filt60", {31'h0, filt60_o}, 32'h1);
    smp(4'h6, 16'h0064);
    rv(4'h6, 16'h0032);
    wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("filt60", {31'h0, filt60_o}, 32'h0);
    ce <= 1'b0;
    smp(4'h2, 16'h0100);
    ce <= 1'b1;
    rv(4'h2, 16'h7E00);
    end_sim();
  end
endmodule
`default_nettype wire
